// ==== sim/host_wd_model.sv ====
// host model toggling the watchdog trigger from its own clock
`timescale 1ns/1ps
module host_wd_model #(
  parameter int HALF = 50
) (
  input wire logic link_clk_i,
  input wire logic en_i,
  output logic trig_o
);
  int cnt_r = 0;
  logic trig_r = 1'h0;
  assign trig_o = trig_r;
  // each level change is one trigger, spaced well inside the window
  always @(posedge link_clk_i) begin
    if (en_i && cnt_r >= HALF - 1) begin
      cnt_r <= 0;
      trig_r <= ~trig_r;
    end else if (en_i) begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule : host_wd_model

// ==== sim/tb_wake_mode_supervisor.sv ====
// self-checking bench for the wake and mode supervisor
`timescale 1ns/1ps
module tb_wake_mode_supervisor;
  localparam int MS = 10;
  localparam logic [4:0] A_ST = wake_mode_pkg::ADDR_STATUS;
  localparam logic [4:0] A_OLD = wake_mode_pkg::ADDR_OLD;
  localparam logic [4:0] A_NEW = wake_mode_pkg::ADDR_NEW;
  localparam logic [4:0] A_CTL = wake_mode_pkg::ADDR_CTRL;
  localparam logic [4:0] A_MOD = wake_mode_pkg::ADDR_MODE;
  logic clk_i = 1'h0;
  logic link_clk = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] sense = 8'h00;
  logic hi = 1'h0;
  logic lo = 1'h1;
  logic wd_trig;
  logic wd_en = 1'h0;
  logic ts_n = 1'h1;
  logic osc = 1'h0;
  logic pwr;
  logic rp;
  logic cn_oe;
  logic cn_n;
  logic [31:0] q;
  int n;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 clk_i = ~clk_i;
  initial begin
    #1;
    forever #80 link_clk = ~link_clk;
  end
  wake_mode_supervisor #(.CYCLES_PER_MS(MS)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sense_inputs_i(sense), .mid_cmp_hi_i(hi), .mid_cmp_lo_i(lo), .watchdog_trigger_i(wd_trig),
    .low_volt_timer_start_n_i(ts_n), .osc_fail_i(osc), .power_enable_o(pwr), .reset_pulse_out_o(rp),
    .change_notify_n_o(cn_n), .change_notify_n_oe_o(cn_oe), .serial_if_reset_o());
  host_wd_model HOST (.link_clk_i(link_clk), .en_i(wd_en), .trig_o(wd_trig));
  // ----
  // shared tasks
  // ----
  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic rd(input logic [4:0] a);
    wb(1'h0, a, 8'h00);
  endtask : rd
  task automatic wait_rp(input logic lvl, input int lim);
    n = 0;
    while (rp !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      fails++;
      $display("[ERR] reset pulse level expected %0h seen timeout", lvl);
    end
  endtask : wait_rp
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    wait_rp(1'h0, 25 * MS);
    chk("por_pulse_len", 32'(n >= 18 * MS && n <= 21 * MS), 32'h1);
    chk("power_run", 32'(pwr), 32'h1);
    chk("notify_run", 32'(cn_oe), 32'h1);
    chk("notify_pin_low", 32'(cn_n), 32'h0);
    rd(A_ST);
    chk("status_por", q, 32'h2);
    rd(A_CTL);
    chk("ctrl_por", q, 32'h3);
    rd(wake_mode_pkg::ADDR_IMPED);
    chk("imped_por", q, 32'h3);
    rd(A_MOD);
    chk("mode_run", q, 32'h0);
    chk("notify_free", 32'(cn_oe), 32'h0);
    rd(A_ST);
    chk("status_cleared", q, 32'h0);
    wb(1'h1, wake_mode_pkg::ADDR_CMD, 8'h04);
    repeat (2) @(posedge clk_i);
    chk("power_cmd_off", 32'(pwr), 32'h0);
    wb(1'h1, wake_mode_pkg::ADDR_CMD, 8'h06);
    repeat (2) @(posedge clk_i);
    chk("power_cmd_on", 32'(pwr), 32'h1);
  endtask : t_reset
  task automatic t_sense;
    sense <= 8'h08;
    repeat (10) @(posedge clk_i);
    chk("notify_change", 32'(cn_oe), 32'h1);
    rd(A_ST);
    chk("status_change", q, 32'h80);
    rd(A_OLD);
    chk("old_before", q, 32'h0);
    rd(A_NEW);
    chk("new_latch", q, 32'h8);
    rd(A_OLD);
    chk("old_shifted", q, 32'h8);
    chk("notify_done", 32'(cn_oe), 32'h0);
  endtask : t_sense
  task automatic t_mask;
    wb(1'h1, A_CTL, 8'h13);
    sense <= 8'h18;
    repeat (10) @(posedge clk_i);
    chk("masked_quiet", 32'(cn_oe), 32'h0);
    rd(A_OLD);
    chk("old_tracks", q, 32'h18);
    rd(A_NEW);
    chk("new_tracks", q, 32'h18);
  endtask : t_mask
  task automatic t_mid;
    wb(1'h1, wake_mode_pkg::ADDR_IMPED, 8'h00);
    lo <= 1'h0;
    repeat (100) @(posedge clk_i);
    rd(A_ST);
    chk("mid_early", q & 32'h40, 32'h0);
    repeat (100) @(posedge clk_i);
    chk("mid_notify", 32'(cn_oe), 32'h1);
    rd(A_ST);
    chk("mid_set", q & 32'h40, 32'h40);
    chk("mid_no_pulse", 32'(rp), 32'h0);
    repeat (200) @(posedge clk_i);
    rd(A_ST);
    chk("mid_repeat", q & 32'h40, 32'h40);
    lo <= 1'h1;
    repeat (10) @(posedge clk_i);
    rd(A_ST);
  endtask : t_mid
  task automatic t_uv;
    ts_n <= 1'h0;
    repeat (10) @(posedge clk_i);
    chk("uv_power_off", 32'(pwr), 32'h0);
    chk("uv_notify_off", 32'(cn_oe), 32'h0);
    ts_n <= 1'h1;
    repeat (2350) @(posedge clk_i);
    chk("uv_still_wait", 32'(pwr), 32'h0);
    wait_rp(1'h1, 300);
    wait_rp(1'h0, 25 * MS);
    chk("uv_power_on", 32'(pwr), 32'h1);
    rd(A_ST);
    chk("uv_status", q & 32'h4, 32'h4);
    ts_n <= 1'h0;
    repeat (100) @(posedge clk_i);
    ts_n <= 1'h1;
    sense <= 8'h09;
    wait_rp(1'h1, 20);
    wait_rp(1'h0, 25 * MS);
    rd(A_ST);
    chk("uv_early", q & 32'h4, 32'h4);
  endtask : t_uv
  task automatic t_standby;
    wb(1'h1, wake_mode_pkg::ADDR_CMD, 8'h01);
    repeat (10) @(posedge clk_i);
    chk("sb_power", 32'(pwr), 32'h0);
    chk("sb_notify", 32'(cn_oe), 32'h0);
    rd(A_MOD);
    chk("sb_mode", q, 32'h2);
    ts_n <= 1'h0;
    repeat (20) @(posedge clk_i);
    chk("sb_ts_ignored", 32'(rp), 32'h0);
    ts_n <= 1'h1;
    sense <= 8'h0D;
    wait_rp(1'h1, 20);
    wait_rp(1'h0, 25 * MS);
    chk("sb_wake_power", 32'(pwr), 32'h1);
    rd(A_ST);
    chk("sb_wake_status", q & 32'h80, 32'h80);
  endtask : t_standby
  task automatic t_wd;
    wb(1'h1, A_CTL, 8'h11);
    wd_en <= 1'h0;
    wait_rp(1'h1, 7000);
    wait_rp(1'h0, 10 * MS);
    chk("wd_pulse_5ms", 32'(n >= 4 * MS && n <= 6 * MS), 32'h1);
    rd(A_ST);
    chk("wd_status", q & 32'h1, 32'h1);
    wd_en <= 1'h1;
  endtask : t_wd
  task automatic t_osc;
    osc <= 1'h1;
    repeat (10) @(posedge clk_i);
    chk("osc_power", 32'(pwr), 32'h0);
    osc <= 1'h0;
    repeat (7 * MS) @(posedge clk_i);
    chk("osc_power_back", 32'(pwr), 32'h1);
    rd(A_ST);
    chk("osc_status", q & 32'h20, 32'h20);
  endtask : t_osc
  task automatic t_missed;
    // bits 0 and 2 still hold unread changes, so only a fresh input can notify
    sense <= 8'h2D;
    repeat (2600) @(posedge clk_i);
    chk("missed_power", 32'(pwr), 32'h0);
    rd(A_MOD);
    chk("missed_mode", q, 32'h2);
    rd(A_ST);
    chk("missed_status", q & 32'h10, 32'h10);
  endtask : t_missed
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    wd_en <= 1'h1;
    t_sense();
    t_mask();
    t_mid();
    t_uv();
    t_standby();
    t_wd();
    t_osc();
    t_missed();
    end_of_test();
  end
endmodule : tb_wake_mode_supervisor

// ==== sim/wake_mode_checker.sv ====
// port assertions for the wake and mode supervisor
`timescale 1ns/1ps
module wake_mode_checker #(
  parameter int CYCLES_PER_MS = 125000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic low_volt_timer_start_n_i,
  input wire logic osc_fail_i,
  input wire logic power_enable_o,
  input wire logic reset_pulse_out_o,
  input wire logic serial_if_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // pulse length counter
  // ----
  logic [31:0] pcnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_pulse_out_o) pcnt_r <= 32'h0;
    else pcnt_r <= pcnt_r + 32'h1;
  end
  // ----
  // assertions
  // ----
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  serial_reset_pulse_a: assert property (serial_if_reset_o |=> !serial_if_reset_o) else $error("serial reset long");
  osc_power_off_a: assert property (osc_fail_i [*5] |-> !power_enable_o) else $error("power on in fault");
  pulse_max_width_a: assert property (reset_pulse_out_o |-> pcnt_r <= 32'(21 * CYCLES_PER_MS))
    else $error("reset pulse too long");
  // pulse excluded: the run-mode start edge is not defined while a pulse is still running
  uv_start_wait_a: assert property ($fell(low_volt_timer_start_n_i) && power_enable_o && !reset_pulse_out_o
    |-> ##[2:8] !power_enable_o) else $error("timer start ignored");
  por_run_entry_a: assert property ($fell(rst_i) |-> reset_pulse_out_o ##[1:2] power_enable_o)
    else $error("run entry after reset wrong");
endmodule : wake_mode_checker

bind wake_mode_supervisor wake_mode_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .low_volt_timer_start_n_i(low_volt_timer_start_n_i),
  .osc_fail_i(osc_fail_i),
  .power_enable_o(power_enable_o),
  .reset_pulse_out_o(reset_pulse_out_o),
  .serial_if_reset_o(serial_if_reset_o)
);

// ==== verilog/wake_mode_pkg.sv ====
// constants, types and register map of the wake and mode supervisor
// What this block does
// - run entry: clear errors, pulse reset, notify, power on
// - wait entry: watchdog off, counters cleared, power off
// - standby entry: power off, inputs may wake device
// - missed read after notify is a run-mode event
// - new latches hold input change until read
// - old register keeps prior state; change notifies host
// - old read harmless; new read shifts and re-arms
// - status read clears status and releases notify
// - upper four inputs maskable from notify and reset
// - masked inputs track live level in both registers
// - mid-level flag is comparator equivalence on input one
// - mid-level sets status bit six after selected delay
// - mid-level bit notifies, optionally resets, held till read
// - flag change restarts delay; repeats while mid-level stays
// - watchdog active after reset pulse; failure pulses reset
// - first trigger within window after pulse accepted
// - oscillator failure resets; bit five set after restart
// - timer start edge; after expiry pulse, notify, power
// - timer starts once per edge, idle after reset
// - timer start only in run; input zero ends early
// - oscillator fault leaves wait without status bit two
// - status bit order as listed, seven down to zero
// - five watchdog failures or missed read enter standby
// - reset pulse width 1, 5, 10, 20 ms, default 20
package wake_mode_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_OLD = 5'h04;
  localparam logic [4:0] ADDR_NEW = 5'h08;
  localparam logic [4:0] ADDR_CTRL = 5'h0C;
  localparam logic [4:0] ADDR_IMPED = 5'h10;
  localparam logic [4:0] ADDR_CMD = 5'h14;
  localparam logic [4:0] ADDR_MODE = 5'h18;

  localparam logic [7:0] STATUS_RST = 8'h02;
  localparam logic [7:0] CTRL_RST = 8'h03;
  localparam logic [1:0] IMPED_RST = 2'h3;

  // status bits
  localparam int ST_CHANGE = 7;
  localparam int ST_MID = 6;
  localparam int ST_OSC = 5;
  localparam int ST_MISSED = 4;
  localparam int ST_UV = 2;
  localparam int ST_DEVRST = 1;
  localparam int ST_WD = 0;

  // control register fields
  localparam int CTRL_WIDTH_LO = 0;
  localparam int CTRL_MASK_LO = 4;
  localparam int CTRL_MIDRST = 2;
  // command register bits (write only)
  localparam int CMD_STANDBY = 0;
  localparam int CMD_POWER = 1;
  localparam int CMD_POWER_SET = 2;

  // ----------------------------------------------------------------
  // timing, in ms; failure and trigger counts
  // ----------------------------------------------------------------
  localparam logic [9:0] PULSE_MS_0 = 10'h001;
  localparam logic [9:0] PULSE_MS_1 = 10'h005;
  localparam logic [9:0] PULSE_MS_2 = 10'h00A;
  localparam logic [9:0] PULSE_MS_3 = 10'h014;
  localparam logic [9:0] UV_MS = 10'h0FA;
  localparam logic [9:0] MID_MS_0 = 10'h010;
  localparam logic [9:0] MID_MS_1 = 10'h020;
  localparam logic [9:0] MID_MS_2 = 10'h040;
  localparam logic [9:0] MID_MS_3 = 10'h080;
  localparam logic [2:0] WD_FAIL_LIMIT = 3'h5;
  localparam logic [1:0] MISSED_TRIGGERS = 2'h2;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_STANDBY = 2'b10
  } mode_t;

  typedef struct packed {
    logic hi;
    logic lo;
  } cmp_t;

endpackage : wake_mode_pkg

// ==== verilog/wake_mode_supervisor.sv ====
// wake and mode supervisor with a classic wishbone register slave
`timescale 1ns/1ps
module wake_mode_supervisor #(
  parameter int CYCLES_PER_MS = 125000,
  parameter logic [9:0] WD_WINDOW_MS = 10'h1F4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] sense_inputs_i,
  input wire logic mid_cmp_hi_i,
  input wire logic mid_cmp_lo_i,
  input wire logic watchdog_trigger_i,
  input wire logic low_volt_timer_start_n_i,
  input wire logic osc_fail_i,
  output logic power_enable_o,
  output logic reset_pulse_out_o,
  output logic change_notify_n_o,
  output logic change_notify_n_oe_o,
  output logic serial_if_reset_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] sync3_r;
  wire [NSYNC-1:0] async_in = {osc_fail_i, low_volt_timer_start_n_i, watchdog_trigger_i,
                               mid_cmp_lo_i, mid_cmp_hi_i, sense_inputs_i[7:2], sense_inputs_i[0]};
  always_ff @(posedge clk_i) begin
    sync1_r <= async_in;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end

  wake_mode_pkg::cmp_t cmp;
  assign cmp = {sync2_r[7], sync2_r[8]};
  wire mid_flag = ~(cmp.hi ^ cmp.lo);
  // level result follows the high comparator: 1, either (0), 0
  wire [7:0] live = {sync2_r[6:1], cmp.hi, sync2_r[0]};
  wire wd_edge = sync2_r[9] ^ sync3_r[9];
  wire ts_fall = sync3_r[10] & ~sync2_r[10];
  wire osc_fail = sync2_r[11];
  wire osc_rise = sync2_r[11] & ~sync3_r[11];
  wire osc_fall = ~sync2_r[11] & sync3_r[11];

  // ----------------------------------------------------------------
  // ms tick
  // ----------------------------------------------------------------
  logic [31:0] pre_r;
  logic tick_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || pre_r == 32'(CYCLES_PER_MS - 1)) begin
      pre_r <= 32'h0;
    end else begin
      pre_r <= pre_r + 32'h1;
    end
    tick_r <= !rst_i && pre_r == 32'(CYCLES_PER_MS - 1);
  end

  // ----------------------------------------------------------------
  // registers and bus decode
  // ----------------------------------------------------------------
  wake_mode_pkg::mode_t mode_r;
  logic [7:0] status_r;
  logic [7:0] old_r;
  logic [7:0] new_r;
  logic [7:0] armed_r;
  logic [7:0] ctrl_r;
  logic [1:0] imped_r;
  logic power_r;
  logic ack_r;
  logic [31:0] dat_r;

  wire access = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = access & wb_we_i & wb_sel_i[0];
  wire rd = access & ~wb_we_i;
  wire rd_status = rd && wb_adr_i == wake_mode_pkg::ADDR_STATUS;
  wire rd_new = rd && wb_adr_i == wake_mode_pkg::ADDR_NEW;
  wire wr_ctrl = wr && wb_adr_i == wake_mode_pkg::ADDR_CTRL;
  wire wr_imped = wr && wb_adr_i == wake_mode_pkg::ADDR_IMPED;
  wire wr_cmd = wr && wb_adr_i == wake_mode_pkg::ADDR_CMD;
  wire in_run = mode_r == wake_mode_pkg::MODE_RUN;

  logic [7:0] rd_byte;
  always_comb begin
    unique case (wb_adr_i)
      wake_mode_pkg::ADDR_STATUS: rd_byte = status_r;
      wake_mode_pkg::ADDR_OLD: rd_byte = old_r;
      wake_mode_pkg::ADDR_NEW: rd_byte = new_r;
      wake_mode_pkg::ADDR_CTRL: rd_byte = ctrl_r;
      wake_mode_pkg::ADDR_IMPED: rd_byte = {6'h00, imped_r};
      wake_mode_pkg::ADDR_MODE: rd_byte = {6'h00, mode_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // unmapped addresses are acked and read as zero; writes there are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= access;
      if (rd) begin
        dat_r <= {24'h000000, rd_byte};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= wake_mode_pkg::CTRL_RST;
      imped_r <= wake_mode_pkg::IMPED_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wb_dat_i[7:0];
      end
      if (wr_imped) begin
        imped_r <= wb_dat_i[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // sense latches
  // ----------------------------------------------------------------
  wire [7:0] mask = {ctrl_r[wake_mode_pkg::CTRL_MASK_LO +: 4], 4'h0};
  logic [7:0] change;
  logic init_r;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sense
      // no change is reported on the edge that loads the latches, so a pin high at release stays quiet
      assign change[gi] = armed_r[gi] & ~mask[gi] & ~init_r & (live[gi] != new_r[gi]);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          armed_r[gi] <= 1'b1;
          new_r[gi] <= 1'b0;
          old_r[gi] <= 1'b0;
        end else if (init_r || mask[gi]) begin
          new_r[gi] <= live[gi];
          old_r[gi] <= live[gi];
          armed_r[gi] <= 1'b1;
        end else if (rd_new) begin
          old_r[gi] <= new_r[gi];
          armed_r[gi] <= 1'b1;
        end else if (change[gi]) begin
          new_r[gi] <= live[gi];
          armed_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  wire any_change = |change;

  // ----------------------------------------------------------------
  // mid-level detect
  // ----------------------------------------------------------------
  logic [9:0] mid_cnt_r;
  logic mid_prev_r;
  logic [9:0] mid_delay;
  always_comb begin
    unique case (imped_r)
      2'h0: mid_delay = wake_mode_pkg::MID_MS_0;
      2'h1: mid_delay = wake_mode_pkg::MID_MS_1;
      2'h2: mid_delay = wake_mode_pkg::MID_MS_2;
      default: mid_delay = wake_mode_pkg::MID_MS_3;
    endcase
  end
  wire mid_hit = mid_flag && tick_r && mid_cnt_r >= mid_delay - 10'h1;
  always_ff @(posedge clk_i) begin
    mid_prev_r <= mid_flag;
    if (rst_i || mid_flag != mid_prev_r || mid_hit) begin
      mid_cnt_r <= 10'h0;
    end else if (mid_flag && tick_r) begin
      mid_cnt_r <= mid_cnt_r + 10'h1;
    end
  end

  // ----------------------------------------------------------------
  // reset pulse
  // ----------------------------------------------------------------
  logic [9:0] pulse_cnt_r;
  logic pulse_r;
  logic [9:0] pulse_len;
  always_comb begin
    unique case (ctrl_r[wake_mode_pkg::CTRL_WIDTH_LO +: 2])
      2'h0: pulse_len = wake_mode_pkg::PULSE_MS_0;
      2'h1: pulse_len = wake_mode_pkg::PULSE_MS_1;
      2'h2: pulse_len = wake_mode_pkg::PULSE_MS_2;
      default: pulse_len = wake_mode_pkg::PULSE_MS_3;
    endcase
  end

  // ----------------------------------------------------------------
  // watchdog, missed read and undervoltage timer
  // ----------------------------------------------------------------
  logic [9:0] wd_cnt_r;
  logic [2:0] wd_err_r;
  logic [1:0] miss_cnt_r;
  logic [9:0] uv_cnt_r;
  logic chi_r;
  logic osc_pend_r;

  wire wd_on = in_run & ~pulse_r;
  wire wd_fail = wd_on && tick_r && wd_cnt_r >= WD_WINDOW_MS - 10'h1;
  wire missed = in_run && chi_r && !rd_status && wd_edge && miss_cnt_r == wake_mode_pkg::MISSED_TRIGGERS - 2'h1;
  wire wd_limit = wd_fail && wd_err_r == wake_mode_pkg::WD_FAIL_LIMIT - 3'h1;
  wire uv_start = in_run && ts_fall;
  wire uv_done = mode_r == wake_mode_pkg::MODE_WAIT && ((tick_r && uv_cnt_r >= wake_mode_pkg::UV_MS - 10'h1) || live[0]);
  wire go_standby = missed || wd_limit || (in_run && wr_cmd && wb_dat_i[wake_mode_pkg::CMD_STANDBY]);
  wire stby = mode_r == wake_mode_pkg::MODE_STANDBY;
  wire stby_wake = stby && (any_change || mid_hit || osc_rise);
  wire wait_wake = uv_done || (mode_r == wake_mode_pkg::MODE_WAIT && osc_rise);
  wire enter_run = stby_wake || wait_wake;
  wire mid_rst = mid_hit && ctrl_r[wake_mode_pkg::CTRL_MIDRST];
  wire fire_pulse = enter_run || (in_run && (wd_fail || osc_rise || mid_rst) && !go_standby);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt_r <= 10'h0;
      wd_err_r <= 3'h0;
      miss_cnt_r <= 2'h0;
      uv_cnt_r <= 10'h0;
    end else begin
      if (!wd_on || wd_edge || wd_fail || uv_start) begin
        wd_cnt_r <= 10'h0;
      end else if (tick_r) begin
        wd_cnt_r <= wd_cnt_r + 10'h1;
      end
      if (enter_run || go_standby || uv_start) begin
        wd_err_r <= 3'h0;
      end else if (wd_fail) begin
        wd_err_r <= wd_err_r + 3'h1;
      end
      if (!in_run || !chi_r || rd_status || missed) begin
        miss_cnt_r <= 2'h0;
      end else if (wd_edge) begin
        miss_cnt_r <= miss_cnt_r + 2'h1;
      end
      if (uv_start || mode_r != wake_mode_pkg::MODE_WAIT) begin
        uv_cnt_r <= 10'h0;
      end else if (tick_r) begin
        uv_cnt_r <= uv_cnt_r + 10'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // status register: hardware set wins over read clear
  // ----------------------------------------------------------------
  logic [7:0] st_set;
  always_comb begin
    st_set = 8'h00;
    st_set[wake_mode_pkg::ST_CHANGE] = any_change;
    st_set[wake_mode_pkg::ST_MID] = mid_hit;
    st_set[wake_mode_pkg::ST_OSC] = osc_fall & osc_pend_r;
    st_set[wake_mode_pkg::ST_MISSED] = missed;
    st_set[wake_mode_pkg::ST_UV] = uv_done;
    st_set[wake_mode_pkg::ST_WD] = wd_fail;
  end
  wire [7:0] status_nxt = (rd_status ? 8'h00 : status_r) | st_set;
  wire chi_event = any_change || mid_hit || missed || uv_done || wd_fail || osc_rise || enter_run;

  // ----------------------------------------------------------------
  // mode machine and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= wake_mode_pkg::MODE_RUN;
      status_r <= wake_mode_pkg::STATUS_RST;
      pulse_r <= 1'b1;
      pulse_cnt_r <= 10'h0;
      chi_r <= 1'b1;
      power_r <= 1'b1;
      osc_pend_r <= 1'b0;
      init_r <= 1'b1;
      serial_if_reset_o <= 1'b1;
    end else begin
      init_r <= 1'b0;
      status_r <= status_nxt;
      serial_if_reset_o <= fire_pulse;
      if (osc_rise) begin
        osc_pend_r <= 1'b1;
      end else if (osc_fall) begin
        osc_pend_r <= 1'b0;
      end
      if (fire_pulse) begin
        pulse_r <= 1'b1;
        pulse_cnt_r <= 10'h0;
      end else if (pulse_r && tick_r) begin
        pulse_cnt_r <= pulse_cnt_r + 10'h1;
        if (pulse_cnt_r >= pulse_len - 10'h1) begin
          pulse_r <= 1'b0;
        end
      end
      if (chi_event) begin
        chi_r <= 1'b1;
      end else if (rd_status) begin
        chi_r <= 1'b0;
      end
      unique case (mode_r)
        wake_mode_pkg::MODE_RUN: begin
          if (go_standby) begin
            mode_r <= wake_mode_pkg::MODE_STANDBY;
            power_r <= 1'b0;
          end else if (uv_start) begin
            mode_r <= wake_mode_pkg::MODE_WAIT;
            power_r <= 1'b0;
          end else if (wr_cmd && wb_dat_i[wake_mode_pkg::CMD_POWER_SET]) begin
            power_r <= wb_dat_i[wake_mode_pkg::CMD_POWER];
          end
        end
        wake_mode_pkg::MODE_WAIT, wake_mode_pkg::MODE_STANDBY: begin
          if (enter_run) begin
            mode_r <= wake_mode_pkg::MODE_RUN;
            power_r <= 1'b1;
          end
        end
        default: begin
          mode_r <= wake_mode_pkg::MODE_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin outputs, all from flip-flops
  // ----------------------------------------------------------------
  // notify pin is only driven in run; in wait and standby it floats
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_enable_o <= 1'b0;
      reset_pulse_out_o <= 1'b1;
      change_notify_n_o <= 1'b0;
      change_notify_n_oe_o <= 1'b0;
    end else begin
      power_enable_o <= power_r & ~osc_fail;
      reset_pulse_out_o <= pulse_r;
      change_notify_n_o <= 1'b0;
      change_notify_n_oe_o <= in_run & (chi_r | osc_fail);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule : wake_mode_supervisor
